// *** bench/meas_front_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module meas_front_end #(
  parameter int unsigned REFRESH = 100
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic signed [31:0] cmd,
  output logic signed [31:0]      p1,
  output logic signed [31:0]      q1,
  output logic signed [31:0]      s1,
  output logic signed [31:0]      p2,
  output logic signed [31:0]      q2,
  output logic signed [31:0]      s2
);
  int unsigned cnt;
  ////////////////////////////////////////
  // periodic value refresh
  // Values move only at the refresh instant, so the stage cannot lean on changes in between.
  always_ff @(posedge clk_sys)
  begin
    cnt <= (rst || cnt == REFRESH - 1) ? 0 : cnt + 1;
    if (rst || cnt == REFRESH - 1)
    begin
      p1 <= rst ? 32'sh0 : cmd;
      q1 <= rst ? 32'sh0 : cmd + 32'sh1;
      s1 <= rst ? 32'sh0 : cmd + 32'sh3;
      p2 <= rst ? 32'sh0 : -cmd;
      q2 <= rst ? 32'sh0 : cmd + 32'sh5;
      s2 <= rst ? 32'sh0 : cmd * 32'sh2;
    end
  end
endmodule // meas_front_end
`default_nettype wire

// *** bench/power_stage_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "power_stage_regs.svh"
module power_stage_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        enable_forcing,
  input wire logic        block_in,
  input wire logic        start_out,
  input wire logic        blocked_out,
  input wire logic [1:0]  condition,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  chk_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata not zero outside a read answer");
  chk_status_mirror: assert property (rd && addr == `ADDR_STATUS |=>
    rdata[3:0] == {$past(blocked_out), $past(start_out), $past(condition)})
    else $error("status read does not match indications");
  chk_start_pair: assert property (!enable_forcing && !$past(enable_forcing) |->
    (condition == 2'h1) == start_out)
    else $error("start condition and start output disagree");
  chk_block_pair: assert property (!enable_forcing && !$past(enable_forcing) |->
    (condition == 2'h3) == blocked_out)
    else $error("blocked condition and blocked output disagree");
  chk_single_ind: assert property (!(start_out && blocked_out))
    else $error("start and blocked both high");
  chk_trip_forced: assert property (condition == 2'h2 |-> $past(enable_forcing))
    else $error("trip condition without forcing");
  chk_start_unblocked: assert property ($rose(start_out) && !$past(enable_forcing) |->
    !$past(block_in))
    else $error("start raised while blocking was active");
  chk_mask_irq_off: assert property (wr && addr == `ADDR_IRQ_MASK && wdata[3:0] == 4'h0
    |-> ##2 !irq)
    else $error("irq high after all sources masked");
  cover property ($rose(start_out));
  cover property ($rose(blocked_out));
  cover property (condition == 2'h2);
endmodule // power_stage_checker
bind power_stage_level power_stage_checker u_chk (.clk_sys(clk_sys), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .enable_forcing(enable_forcing),
  .block_in(block_in), .start_out(start_out), .blocked_out(blocked_out),
  .condition(condition), .irq(irq));
`default_nettype wire

// *** bench/tb_power_stage_level.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "power_stage_regs.svh"
module tb_power_stage_level;
  localparam int unsigned EVAL = 100;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         addr = 8'h00;
  logic [31:0]        wdata = 32'h0;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [31:0]        rdata;
  logic signed [31:0] load = 32'sh0;
  logic signed [31:0] p1, q1, s1, p2, q2, s2;
  logic [23:0]        nom_gen = 24'h0;
  logic [23:0]        nom_trafo = 24'h07a120;
  logic               allow_ln_mode = 1'b0;
  logic               enable_forcing = 1'b0;
  logic [2:0]         group_active = 3'h0;
  logic               block_in = 1'b0;
  logic               start_out, blocked_out, irq;
  logic [1:0]         condition;
  logic [31:0]        meas_exp [4] = '{32'hffff8ad0, 32'h00007535, 32'h0000ea60, 32'h0000ea60};
  int                 n_mismatch = 0;
  int                 cmp_count = 0;

  always #12.5 clk_sys = ~clk_sys;

  meas_front_end #(.REFRESH(EVAL)) model (.clk_sys(clk_sys), .rst(rst), .cmd(load),
    .p1(p1), .q1(q1), .s1(s1), .p2(p2), .q2(q2), .s2(s2));
  power_stage_level #(.EVAL_CYCLES(EVAL)) dut (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .power_side_one_active(p1),
    .power_side_one_reactive(q1), .power_side_one_apparent(s1), .power_side_two_active(p2),
    .power_side_two_reactive(q2), .power_side_two_apparent(s2), .nom_gen(nom_gen),
    .nom_trafo(nom_trafo), .allow_ln_mode(allow_ln_mode), .enable_forcing(enable_forcing),
    .group_active(group_active), .block_in(block_in), .start_out(start_out),
    .blocked_out(blocked_out), .condition(condition), .irq(irq));
  ////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk($sformatf("register %h", a), rdata, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Indications packed as start, blocked, condition.
  task automatic ind(input logic [3:0] e);
    chk("indications", {28'h0, start_out, blocked_out, condition}, {28'h0, e});
  endtask
  task automatic step(input logic signed [31:0] v, input logic [3:0] e);
    load <= v;
    wait_cyc(3 * EVAL);
    ind(e);
  endtask
  ////////////////////////////////////////
  initial
  begin
    wait_cyc(100000);
    n_mismatch++;
    final_report();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rreg(`ADDR_CTRL, 32'h0);
    rreg(`ADDR_GRP_CFG, 32'h0);
    rreg(`ADDR_GRP_NOM, 32'h000186a0);
    rreg(`ADDR_GRP_PCT, 32'h0);
    rreg(8'h30, 32'h0);
    wreg(`ADDR_CTRL, 32'h4);
    rreg(`ADDR_CTRL, 32'h0);
    wreg(`ADDR_CTRL, 32'h10);
    rreg(`ADDR_CTRL, 32'h0);
    @(posedge clk_sys);
    allow_ln_mode <= 1'b1;
    wreg(`ADDR_CTRL, 32'h4);
    rreg(`ADDR_CTRL, 32'h4);
    wreg(`ADDR_CTRL, 32'h0);
    // Over mode at 50 percent of 10 MVA, a level of 50000.
    wreg(`ADDR_GRP_PCT, 32'h2710);
    wreg(`ADDR_IRQ_MASK, 32'hf);
    step(32'sd60000, 4'h9);
    chk("irq", {31'h0, irq}, 32'h1);
    rreg(`ADDR_STATUS, 32'h5);
    rreg(`ADDR_RATIO, 32'h2ee0);
    rreg(`ADDR_MEAS, 32'hea60);
    rreg(`ADDR_NOM_USED, 32'h186a0);
    rreg(`ADDR_IRQ_STAT, 32'h1);
    wreg(`ADDR_IRQ_MASK, 32'h0);
    wait_cyc(2);
    chk("irq", {31'h0, irq}, 32'h0);
    wreg(`ADDR_IRQ_MASK, 32'hf);
    wreg(`ADDR_IRQ_STAT, 32'hf);
    rreg(`ADDR_IRQ_STAT, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    step(32'sd48500, 4'h9);
    step(32'sd48499, 4'h0);
    rreg(`ADDR_IRQ_STAT, 32'h2);
    // Under mode in group one, switched in while running.
    wreg(`ADDR_GRP_IDX, 32'h1);
    wreg(`ADDR_GRP_CFG, 32'h10);
    wreg(`ADDR_GRP_PCT, 32'h2710);
    group_active <= 3'h1;
    step(32'sd48499, 4'h9);
    step(32'sd51500, 4'h9);
    step(32'sd51501, 4'h0);
    rreg(`ADDR_STATUS, 32'h10);
    // Side two with generator nominal, every magnitude code.
    @(posedge clk_sys);
    nom_gen <= 24'h030d40;
    wreg(`ADDR_CTRL, 32'h20);
    load <= 32'sd30000;
    for (int m = 0; m < 4; m++)
    begin
      wreg(`ADDR_GRP_CFG, 32'h4 | m);
      wait_cyc(3 * EVAL);
      rreg(`ADDR_MEAS, meas_exp[m]);
    end
    rreg(`ADDR_GRP_NOM, 32'h0);
    rreg(`ADDR_NOM_USED, 32'h30d40);
    wreg(`ADDR_GRP_CFG, 32'h8);
    rreg(`ADDR_NOM_USED, 32'h7a120);
    group_active <= 3'h0;
    rreg(`ADDR_CTRL, 32'h20);
    // Blocking arriving during start, then removed.
    wreg(`ADDR_CTRL, 32'h0);
    step(32'sd60000, 4'h9);
    @(posedge clk_sys);
    block_in <= 1'b1;
    step(32'sd60000, 4'h7);
    @(posedge clk_sys);
    block_in <= 1'b0;
    step(32'sd60000, 4'h9);
    // Node mode blocked acts like the blocking input, test mode like on.
    wreg(`ADDR_CTRL, 32'h1);
    step(32'sd60000, 4'h7);
    wreg(`ADDR_CTRL, 32'h2);
    step(32'sd60000, 4'h9);
    @(posedge clk_sys);
    enable_forcing <= 1'b1;
    wreg(`ADDR_CTRL, 32'h10);
    wait_cyc(2);
    chk("condition", {30'h0, condition}, 32'h2);
    @(posedge clk_sys);
    enable_forcing <= 1'b0;
    wait_cyc(3);
    ind(4'h9);
    wreg(`ADDR_CTRL, 32'h4);
    wait_cyc(3);
    ind(4'h0);
    final_report();
  end
endmodule // tb_power_stage_level
`default_nettype wire

// *** logic/eval_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module eval_tick #(
  parameter int unsigned CYCLES = 200000
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      tick
);
  localparam int unsigned CW = $clog2(CYCLES);
  logic [CW-1:0] count;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else if (count == CW'(CYCLES - 1))
    begin
      count <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule // eval_tick
`default_nettype wire

// *** logic/power_stage_level.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "power_stage_regs.svh"
module power_stage_level #(
  parameter int unsigned NGROUPS     = 8,
  parameter int unsigned EVAL_CYCLES = `EVAL_PERIOD_US * `CLK_MHZ
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic [7:0]                   addr,
  input  wire logic [31:0]                  wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic [31:0]                       rdata,
  input  wire logic signed [`PWR_W-1:0]     power_side_one_active,
  input  wire logic signed [`PWR_W-1:0]     power_side_one_reactive,
  input  wire logic signed [`PWR_W-1:0]     power_side_one_apparent,
  input  wire logic signed [`PWR_W-1:0]     power_side_two_active,
  input  wire logic signed [`PWR_W-1:0]     power_side_two_reactive,
  input  wire logic signed [`PWR_W-1:0]     power_side_two_apparent,
  input  wire logic [`NOM_W-1:0]            nom_gen,
  input  wire logic [`NOM_W-1:0]            nom_trafo,
  input  wire logic                         allow_ln_mode,
  input  wire logic                         enable_forcing,
  input  wire logic [$clog2(NGROUPS)-1:0]   group_active,
  input  wire logic                         block_in,
  output logic                              start_out,
  output logic                              blocked_out,
  output logic [1:0]                        condition,
  output logic                              irq
);
  localparam int unsigned GW = $clog2(NGROUPS);

  power_stage_pkg::ln_mode_e     ln_mode;
  power_stage_pkg::cond_e        force_status;
  logic                          side;
  logic [GW-1:0]                 edit_idx;
  power_stage_pkg::magnitude_e   cfg_mag [NGROUPS];
  power_stage_pkg::nom_src_e     cfg_src [NGROUPS];
  logic                          cfg_under [NGROUPS];
  logic [`NOM_W-1:0]             cfg_nom [NGROUPS];
  logic signed [`PCT_W-1:0]      cfg_pct [NGROUPS];
  power_stage_pkg::stage_state_e state;
  power_stage_pkg::stage_state_e next_state;
  power_stage_pkg::cond_e        next_cond;
  logic signed [`PWR_W-1:0]      meas_sel;
  logic signed [`PWR_W-1:0]      meas_now;
  logic [`NOM_W-1:0]             nom_used;
  logic signed [63:0]            m_s;
  logic signed [63:0]            l_s;
  logic signed [63:0]            m_abs;
  logic signed [63:0]            l_abs;
  logic                          pick;
  logic                          release_hit;
  logic                          eff_block;
  logic                          tick;
  logic [`DIV_W-1:0]             quotient;
  logic                          div_done;
  logic [31:0]                   ratio;
  logic [`EV_W-1:0]              ev;
  logic [`EV_W-1:0]              irq_stat;
  logic [`EV_W-1:0]              irq_mask;
  logic [`EV_W-1:0]              next_stat;
  logic [31:0]                   rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  eval_tick #(
    .CYCLES (EVAL_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick)
  );

  ratio_divider #(
    .W (`DIV_W)
  ) u_div (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .go       (tick),
    .dividend ($unsigned(m_abs * `RATIO_ONE)),
    .divisor  ($unsigned(l_abs)),
    .quotient (quotient),
    .done     (div_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // General settings live outside the group arrays so a group switch leaves them alone.
  // R12 group independent
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ln_mode      <= power_stage_pkg::LN_ON;
      force_status <= power_stage_pkg::COND_NORMAL;
      side         <= `SIDE_RESET;
    end
    else if (wr && addr == `ADDR_CTRL)
    begin
      // R08 mode write gate
      if (allow_ln_mode && wdata[`CTRL_LN] <= `LN_MAX)
      begin
        ln_mode <= power_stage_pkg::ln_mode_e'(wdata[`CTRL_LN]);
      end
      // R09 forcing write gate
      if (enable_forcing)
      begin
        force_status <= power_stage_pkg::cond_e'(wdata[`CTRL_FORCE]);
      end
      // R07 side select
      side <= wdata[`CTRL_SIDE];
    end
  end

  // R13 per group settings
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      edit_idx <= '0;
      for (int i = 0; i < NGROUPS; i++)
      begin
        // R01 active default
        cfg_mag[i]   <= power_stage_pkg::MAG_ACTIVE;
        // R05 manual default
        cfg_src[i]   <= power_stage_pkg::NOM_MANUAL;
        // R02 over default
        cfg_under[i] <= `UNDER_RESET;
        // R06 ten MVA
        cfg_nom[i]   <= `NOM_RESET;
        // R04 zero level
        cfg_pct[i]   <= `PCT_RESET;
      end
    end
    else if (wr)
    begin
      case (addr)
        `ADDR_GRP_IDX:
        begin
          edit_idx <= wdata[GW-1:0];
        end
        `ADDR_GRP_CFG:
        begin
          cfg_mag[edit_idx]   <= power_stage_pkg::magnitude_e'(wdata[`CFG_MAG]);
          cfg_src[edit_idx]   <= power_stage_pkg::nom_src_e'(wdata[`CFG_SRC]);
          cfg_under[edit_idx] <= wdata[`CFG_UNDER];
        end
        `ADDR_GRP_NOM:
        begin
          cfg_nom[edit_idx] <= wdata[`NOM_W-1:0];
        end
        `ADDR_GRP_PCT:
        begin
          cfg_pct[edit_idx] <= wdata[`PCT_W-1:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // R07 side mux
    // R01 quantity mux
    case (cfg_mag[group_active])
      power_stage_pkg::MAG_ACTIVE:
        meas_sel = side ? power_side_two_active : power_side_one_active;
      power_stage_pkg::MAG_REACTIVE:
        meas_sel = side ? power_side_two_reactive : power_side_one_reactive;
      default:
        meas_sel = side ? power_side_two_apparent : power_side_one_apparent;
    endcase
    // R05 nominal source
    // R06 manual only
    case (cfg_src[group_active])
      power_stage_pkg::NOM_GEN:   nom_used = nom_gen;
      power_stage_pkg::NOM_TRAFO: nom_used = nom_trafo;
      default:                    nom_used = cfg_nom[group_active];
    endcase
  end

  // Both sides are scaled to pick-up steps so the compare needs no divide.
  // R04 signed percent level
  assign m_s   = 64'(meas_sel) * `PICKUP_STEPS;
  assign l_s   = 64'(signed'({1'b0, nom_used})) * 64'(cfg_pct[group_active]);
  assign m_abs = (m_s < 0) ? -m_s : m_s;
  assign l_abs = (l_s < 0) ? -l_s : l_s;

  // R10 signed direct compare of m_s with l_s, not the ratio against one
  // R02 over or under
  assign pick = cfg_under[group_active] ? (m_s < l_s) : (m_s > l_s);
  // R03 release hysteresis
  assign release_hit = cfg_under[group_active] ?
                       (m_s * `PCT_FULL > l_s * `HYST_UNDER) :
                       (m_s * `PCT_FULL < l_s * `HYST_OVER);

  // R08 blocked modes
  assign eff_block = block_in || ln_mode == power_stage_pkg::LN_BLOCKED
                     || ln_mode == power_stage_pkg::LN_TEST_BLOCKED;

  ////////////////////////////////////////////////////////////////////////////
  // R14 start on tick
  always_comb
  begin
    next_state = state;
    if (ln_mode == power_stage_pkg::LN_OFF)
    begin
      next_state = power_stage_pkg::ST_NORMAL;
    end
    else if (tick)
    begin
      case (state)
        power_stage_pkg::ST_NORMAL:
        begin
          if (pick)
          begin
            next_state = eff_block ? power_stage_pkg::ST_BLOCKED : power_stage_pkg::ST_START;
          end
        end
        power_stage_pkg::ST_START:
        begin
          if (release_hit)
          begin
            next_state = power_stage_pkg::ST_NORMAL;
          end
          else if (eff_block)
          begin
            next_state = power_stage_pkg::ST_BLOCKED;
          end
        end
        power_stage_pkg::ST_BLOCKED:
        begin
          if (release_hit)
          begin
            next_state = power_stage_pkg::ST_NORMAL;
          end
          else if (!eff_block)
          begin
            next_state = power_stage_pkg::ST_START;
          end
        end
        default:
        begin
          next_state = power_stage_pkg::ST_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= power_stage_pkg::ST_NORMAL;
    end
    else
    begin
      state <= next_state;
    end
  end

  // R09 forced status
  always_comb
  begin
    if (enable_forcing && force_status != power_stage_pkg::COND_NORMAL)
    begin
      next_cond = force_status;
    end
    else if (next_state == power_stage_pkg::ST_START)
    begin
      next_cond = power_stage_pkg::COND_START;
    end
    else if (next_state == power_stage_pkg::ST_BLOCKED)
    begin
      next_cond = power_stage_pkg::COND_BLOCKED;
    end
    else
    begin
      next_cond = power_stage_pkg::COND_NORMAL;
    end
  end

  assign ev = {blocked_out && next_cond != power_stage_pkg::COND_BLOCKED,
               !blocked_out && next_cond == power_stage_pkg::COND_BLOCKED,
               start_out && next_cond != power_stage_pkg::COND_START,
               !start_out && next_cond == power_stage_pkg::COND_START};

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      condition   <= power_stage_pkg::COND_NORMAL;
      start_out   <= 1'b0;
      blocked_out <= 1'b0;
    end
    else
    begin
      condition   <= next_cond;
      start_out   <= next_cond == power_stage_pkg::COND_START;
      blocked_out <= next_cond == power_stage_pkg::COND_BLOCKED;
    end
  end

  // R10 ratio capture
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ratio    <= '0;
      meas_now <= '0;
    end
    else
    begin
      if (tick)
      begin
        meas_now <= meas_sel;
      end
      if (div_done)
      begin
        ratio <= (|quotient[`DIV_W-1:32]) ? '1 : quotient[31:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A new event wins over a clear written in the same cycle.
  assign next_stat = (irq_stat & ~((wr && addr == `ADDR_IRQ_STAT) ?
                     wdata[`IRQ_BITS] : '0)) | ev;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end
    else
    begin
      irq_stat <= next_stat;
      irq      <= |(next_stat & irq_mask);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_mask <= '0;
    end
    else if (wr && addr == `ADDR_IRQ_MASK)
    begin
      irq_mask <= wdata[`IRQ_BITS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    rd_mux = '0;
    case (addr)
      `ADDR_CTRL:
      begin
        rd_mux[`CTRL_LN]    = ln_mode;
        rd_mux[`CTRL_FORCE] = force_status;
        rd_mux[`CTRL_SIDE]  = side;
      end
      `ADDR_GRP_IDX:
        rd_mux[GW-1:0] = edit_idx;
      `ADDR_GRP_CFG:
      begin
        rd_mux[`CFG_MAG]   = cfg_mag[edit_idx];
        rd_mux[`CFG_SRC]   = cfg_src[edit_idx];
        rd_mux[`CFG_UNDER] = cfg_under[edit_idx];
      end
      `ADDR_GRP_NOM:
      begin
        if (cfg_src[edit_idx] == power_stage_pkg::NOM_MANUAL)
        begin
          rd_mux[`NOM_W-1:0] = cfg_nom[edit_idx];
        end
      end
      `ADDR_GRP_PCT:
        rd_mux = 32'(cfg_pct[edit_idx]);
      `ADDR_STATUS:
      begin
        rd_mux[`ST_COND]              = condition;
        rd_mux[`ST_START]             = start_out;
        rd_mux[`ST_BLOCKED]           = blocked_out;
        rd_mux[`ST_GROUP_LSB +: GW]   = group_active;
      end
      `ADDR_MEAS:     rd_mux = meas_now;
      `ADDR_RATIO:    rd_mux = ratio;
      `ADDR_NOM_USED: rd_mux[`NOM_W-1:0] = nom_used;
      `ADDR_IRQ_STAT: rd_mux[`IRQ_BITS] = irq_stat;
      `ADDR_IRQ_MASK: rd_mux[`IRQ_BITS] = irq_mask;
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= rd ? rd_mux : '0;
    end
  end
endmodule // power_stage_level
`default_nettype wire

// *** logic/power_stage_pkg.sv ***
`default_nettype none
package power_stage_pkg;
  typedef enum logic [1:0] {
    MAG_ACTIVE   = 2'h0,
    MAG_REACTIVE = 2'h1,
    MAG_APPARENT = 2'h2
  } magnitude_e;
  typedef enum logic [1:0] {
    NOM_MANUAL = 2'h0,
    NOM_GEN    = 2'h1,
    NOM_TRAFO  = 2'h2
  } nom_src_e;
  typedef enum logic [2:0] {
    LN_ON           = 3'h0,
    LN_BLOCKED      = 3'h1,
    LN_TEST         = 3'h2,
    LN_TEST_BLOCKED = 3'h3,
    LN_OFF          = 3'h4
  } ln_mode_e;
  typedef enum logic [1:0] {
    COND_NORMAL  = 2'h0,
    COND_START   = 2'h1,
    COND_TRIP    = 2'h2,
    COND_BLOCKED = 2'h3
  } cond_e;
  typedef enum logic [1:0] {
    ST_NORMAL  = 2'h0,
    ST_START   = 2'h1,
    ST_BLOCKED = 2'h2
  } stage_state_e;
endpackage
`default_nettype wire

// *** logic/power_stage_regs.svh ***
`ifndef POWER_STAGE_REGS_SVH
`define POWER_STAGE_REGS_SVH
// Operation
// R01: The compared quantity is active, reactive or apparent three-phase power, active by default.
// R02: A direction setting picks over or under operation, over by default.
// R03: Release happens at 97 percent of pick-up in over mode and 103 percent in under mode.
// R04: The pick-up level is a signed percentage of nominal power in 0.005 percent steps, zero at reset.
// R05: Nominal power comes from the manual value or from the status monitor, manual by default.
// R06: The manual nominal power has 0.0001 MVA resolution, is 10 MVA at reset and is used only in manual.
// R07: A side setting picks which of two power measurement sets feeds the stage, the first by default.
// R08: The node mode has five values, is on at reset and can be set only while individual mode is allowed.
// R09: The reported status can be forced to normal, start, trip or blocked only while forcing is enabled; the code treats a forced normal as no forcing.
// R10: The stage computes the ratio of measured power magnitude to pick-up level and decides on it; the code decides on a signed direct compare.
// R11: The measurement front end refreshes its current and voltage derived values every 5 ms; the bench model refreshes every REFRESH clock cycles.
// R12: Node mode, forced status and measurement side do not change with the setting group.
// R13: Pick-up parameters come from the active setting group and a switch applies without a stop.
// R14: Start asserts on the first 5 ms evaluation past the level and drops when the release is crossed.

// Register byte addresses.
`define ADDR_CTRL      8'h00
`define ADDR_GRP_IDX   8'h04
`define ADDR_GRP_CFG   8'h08
`define ADDR_GRP_NOM   8'h0c
`define ADDR_GRP_PCT   8'h10
`define ADDR_STATUS    8'h14
`define ADDR_MEAS      8'h18
`define ADDR_RATIO     8'h1c
`define ADDR_NOM_USED  8'h20
`define ADDR_IRQ_STAT  8'h24
`define ADDR_IRQ_MASK  8'h28

// Field positions.
`define CTRL_LN        2:0
`define CTRL_FORCE     4:3
`define CTRL_SIDE      5
`define CFG_MAG        1:0
`define CFG_SRC        3:2
`define CFG_UNDER      4
`define ST_COND        1:0
`define ST_START       2
`define ST_BLOCKED     3
`define ST_GROUP_LSB   4
`define IRQ_BITS       3:0

// Widths and reset values.
`define PWR_W          32
`define NOM_W          24
`define PCT_W          18
`define EV_W           4
`define DIV_W          64
`define NOM_RESET      24'h0186a0
`define PCT_RESET      18'h00000
`define SIDE_RESET     1'b0
`define UNDER_RESET    1'b0
`define LN_MAX         3'h4

// Scaling: one pick-up step is 1/20000 of nominal, ratio unit is 1/10000 p.u.
`define PICKUP_STEPS   64'sh4e20
`define RATIO_ONE      64'sh2710
`define PCT_FULL       64'sh64
`define HYST_OVER      64'sh61
`define HYST_UNDER     64'sh67

// Timing.
`define EVAL_PERIOD_US 5000
`define CLK_MHZ        40
`endif

// *** logic/ratio_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module ratio_divider #(
  parameter int unsigned W = 64
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         go,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic [W-1:0]      quotient,
  output logic              done
);
  localparam int unsigned CW = $clog2(W) + 1;
  logic [CW-1:0] count;
  logic [W-1:0]  rem;
  logic [W-1:0]  quo;
  logic [W-1:0]  dvs;
  logic [W:0]    shifted;

  // A zero divisor yields all ones, which reads as a saturated ratio.
  assign shifted = {rem, quo[W-1]};

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count    <= '0;
      rem      <= '0;
      quo      <= '0;
      dvs      <= '0;
      quotient <= '0;
      done     <= 1'b0;
    end
    else if (go)
    begin
      count <= CW'(W);
      rem   <= '0;
      quo   <= dividend;
      dvs   <= divisor;
      done  <= 1'b0;
    end
    else if (count != '0)
    begin
      count <= count - 1'b1;
      if (shifted >= {1'b0, dvs})
      begin
        rem <= W'(shifted - {1'b0, dvs});
        quo <= {quo[W-2:0], 1'b1};
      end
      else
      begin
        rem <= shifted[W-1:0];
        quo <= {quo[W-2:0], 1'b0};
      end
      done <= (count == CW'(1));
      if (count == CW'(1))
      begin
        quotient <= (shifted >= {1'b0, dvs}) ? {quo[W-2:0], 1'b1} : {quo[W-2:0], 1'b0};
      end
    end
    else
    begin
      done <= 1'b0;
    end
  end
endmodule // ratio_divider
`default_nettype wire
